// *** hdl/chgctl_deglitch.sv ***
`timescale 1ns/100ps
// Functional notes
// - in constant-voltage phase, taper-current detect ends charging at once
// - after termination, a fall below recharge threshold starts a new cycle
// - loss of input supply forces the low-power sleep state
// - status a,b: precharge on,on; fast on,off; done off,on; others off,off
// - status outputs are open-drain: on pulls low, off releases the pin
// - power-good pulls low with valid input, released in sleep
// - enable input low permits charging; high stops charging, low-power state
// - falling edge of enable input resets all timers and the timer fault
// - voltage select low picks 4.2 V target, high picks 4.06 V
// - fault above recharge threshold holds until output falls below, then restarts
// - power-on reset or enable toggle also clears a latched timer fault
// - fault below recharge threshold keeps fault-detect current on while below
// - rising above threshold stops fault-detect current, then above-threshold recovery follows
// - below precharge exit threshold: precharge current and safety timer, fault on expiry
// - fast-charge safety timer expiry without termination switches off, signals fault
`include "chgctl_params.svh"

module chgctl #(
  parameter int unsigned        NUM_SENSE    = `CHGCTL_NUM_IN,
  parameter int unsigned        DEGLITCH_CYC = `CHGCTL_DEGLITCH_CYC,
  parameter int unsigned        TIMER_W      = 41,
  parameter logic [TIMER_W-1:0] PRECHG_CYC   = TIMER_W'(`CHGCTL_PRECHG_CYC),
  parameter logic [TIMER_W-1:0] FAST_CYC     = TIMER_W'(`CHGCTL_FAST_CYC)
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         arst_n_i,
  input  wire chgctl_pkg::chgctl_sense_type sense_i,
  input  wire logic                         charge_enable_n_i,
  input  wire logic                         regulation_voltage_select_i,
  input  wire logic                         temp_suspend_i,
  output logic                              status_out_a_oe_o,
  output logic                              status_out_b_oe_o,
  output logic                              power_good_n_oe_o,
  output logic                              charge_on_o,
  output logic                              precharge_o,
  output logic                              fault_current_o,
  output logic                              low_power_o,
  output logic [12:0]                       vreg_target_mv_o,
  output chgctl_pkg::chgctl_state_type      state_o
);

  localparam logic [12:0] VREG_LO_MV = 13'(`CHGCTL_VSEL_LO_MV);
  localparam logic [12:0] VREG_HI_MV = 13'(`CHGCTL_VSEL_HI_MV);

  logic [NUM_SENSE-1:0]         sense_raw;
  logic [NUM_SENSE-1:0]         sense_clean;
  chgctl_pkg::chgctl_sense_type sense_q;
  logic                         enable_n_q;
  logic                         vsel_q;
  logic                         temp_susp_q;
  logic                         enable_n_prev_ff;
  logic                         enable_fall;
  chgctl_pkg::chgctl_state_type state_ff;
  chgctl_pkg::chgctl_state_type nxt_state;
  logic                         start_cycle;
  logic                         timer_clr;
  logic [TIMER_W-1:0]           prechg_cnt_ff;
  logic [TIMER_W-1:0]           fast_cnt_ff;
  logic                         prechg_expired;
  logic                         fast_expired;
  logic                         fault_low_ff;
  logic                         nxt_fault_low;
  chgctl_pkg::chgctl_stat_type  stat_ff;
  logic                         pg_oe_ff;
  logic                         charge_on_ff;
  logic                         precharge_ff;
  logic                         fault_cur_ff;
  logic                         low_power_ff;
  logic [12:0]                  vreg_ff;

  // status pin pattern for a state; on means the pin is pulled low
  function automatic chgctl_pkg::chgctl_stat_type stat_of(input chgctl_pkg::chgctl_state_type s);
    chgctl_pkg::chgctl_stat_type r;
    r = '0;
    unique case (s)
      chgctl_pkg::ST_PRECHG: begin
        r.on_a = 1'b1;
        r.on_b = 1'b1;
      end
      chgctl_pkg::ST_FAST: begin
        r.on_a = 1'b1;
        r.on_b = 1'b0;
      end
      chgctl_pkg::ST_DONE: begin
        r.on_a = 1'b0;
        r.on_b = 1'b1;
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // first charging phase of a cycle depends on the battery level
  function automatic chgctl_pkg::chgctl_state_type entry_state(input logic above_lowv);
    return above_lowv ? chgctl_pkg::ST_FAST : chgctl_pkg::ST_PRECHG;
  endfunction

  function automatic logic charging(input chgctl_pkg::chgctl_state_type s);
    return (s == chgctl_pkg::ST_PRECHG) || (s == chgctl_pkg::ST_FAST);
  endfunction

  function automatic logic idle_power(input chgctl_pkg::chgctl_state_type s);
    return (s == chgctl_pkg::ST_SLEEP) || (s == chgctl_pkg::ST_DISABLE);
  endfunction

  // comparator inputs: sync and deglitch each bit alike
  assign sense_raw = sense_i;

  for (genvar gi = 0; gi < NUM_SENSE; gi++) begin : g_sense
    chgctl_deglitch #(
      .CYCLES (DEGLITCH_CYC),
      .INIT   (1'b0)
    ) u_dg (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .raw_i     (sense_raw[gi]),
      .clean_o   (sense_clean[gi])
    );
  end

  assign sense_q = chgctl_pkg::chgctl_sense_type'(sense_clean);

  // enable starts from its disabled level, so reset never looks like a falling edge
  chgctl_deglitch #(
    .CYCLES (DEGLITCH_CYC),
    .INIT   (1'b1)
  ) u_dg_enable (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .raw_i     (charge_enable_n_i),
    .clean_o   (enable_n_q)
  );

  chgctl_deglitch #(
    .CYCLES (DEGLITCH_CYC),
    .INIT   (1'b0)
  ) u_dg_vsel (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .raw_i     (regulation_voltage_select_i),
    .clean_o   (vsel_q)
  );

  chgctl_deglitch #(
    .CYCLES (DEGLITCH_CYC),
    .INIT   (1'b0)
  ) u_dg_temp (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .raw_i     (temp_suspend_i),
    .clean_o   (temp_susp_q)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_n_prev_ff <= 1'b1;
    end else begin
      enable_n_prev_ff <= enable_n_q;
    end
  end

  assign enable_fall = enable_n_prev_ff & ~enable_n_q;

  assign prechg_expired = (prechg_cnt_ff == (PRECHG_CYC - TIMER_W'(1)));
  assign fast_expired   = (fast_cnt_ff == (FAST_CYC - TIMER_W'(1)));

  // priority: no supply, then disabled, then temperature hold, then the charge flow
  always_comb begin
    nxt_state   = state_ff;
    start_cycle = 1'b0;
    if (!sense_q.in_present) begin
      nxt_state = chgctl_pkg::ST_SLEEP;
    end else if (enable_n_q) begin
      nxt_state = chgctl_pkg::ST_DISABLE;
    end else if (temp_susp_q) begin
      nxt_state = chgctl_pkg::ST_SUSPEND;
    end else begin
      unique case (state_ff)
        chgctl_pkg::ST_SLEEP, chgctl_pkg::ST_DISABLE: begin
          start_cycle = 1'b1;
          nxt_state   = entry_state(sense_q.above_lowv);
        end
        chgctl_pkg::ST_SUSPEND: begin
          // timers were held, so resuming does not restart them
          nxt_state = entry_state(sense_q.above_lowv);
        end
        chgctl_pkg::ST_PRECHG: begin
          if (sense_q.above_lowv) begin
            nxt_state = chgctl_pkg::ST_FAST;
          end else if (prechg_expired) begin
            nxt_state = chgctl_pkg::ST_FAULT;
          end
        end
        chgctl_pkg::ST_FAST: begin
          if (sense_q.in_regulation && sense_q.taper_term) begin
            nxt_state = chgctl_pkg::ST_DONE;
          end else if (fast_expired) begin
            nxt_state = chgctl_pkg::ST_FAULT;
          end
        end
        chgctl_pkg::ST_DONE: begin
          if (sense_q.below_rch) begin
            start_cycle = 1'b1;
            nxt_state   = entry_state(sense_q.above_lowv);
          end
        end
        chgctl_pkg::ST_FAULT: begin
          if (!fault_low_ff && sense_q.below_rch) begin
            start_cycle = 1'b1;
            nxt_state   = entry_state(sense_q.above_lowv);
          end
        end
        default: begin
          nxt_state = chgctl_pkg::ST_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= chgctl_pkg::ST_SLEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timers sit at zero while the charger is idle
  assign timer_clr = start_cycle | enable_fall | idle_power(state_ff);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prechg_cnt_ff <= '0;
    end else if (timer_clr) begin
      prechg_cnt_ff <= '0;
    end else if ((state_ff == chgctl_pkg::ST_PRECHG) && !prechg_expired) begin
      prechg_cnt_ff <= prechg_cnt_ff + TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fast_cnt_ff <= '0;
    end else if (timer_clr) begin
      fast_cnt_ff <= '0;
    end else if ((state_ff == chgctl_pkg::ST_FAST) && !fast_expired) begin
      fast_cnt_ff <= fast_cnt_ff + TIMER_W'(1);
    end
  end

  // remembers that the fault began below the recharge threshold
  always_comb begin
    nxt_fault_low = fault_low_ff;
    if ((nxt_state == chgctl_pkg::ST_FAULT) && (state_ff != chgctl_pkg::ST_FAULT)) begin
      nxt_fault_low = sense_q.below_rch;
    end else if ((state_ff != chgctl_pkg::ST_FAULT) || !sense_q.below_rch) begin
      nxt_fault_low = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_low_ff <= 1'b0;
    end else begin
      fault_low_ff <= nxt_fault_low;
    end
  end

  // outputs other than vreg_target_mv_o are registered from the next state so they line up with state_o
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= stat_of(nxt_state);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pg_oe_ff <= 1'b0;
    end else begin
      pg_oe_ff <= (nxt_state != chgctl_pkg::ST_SLEEP);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge_on_ff <= 1'b0;
      precharge_ff <= 1'b0;
    end else begin
      charge_on_ff <= charging(nxt_state);
      precharge_ff <= (nxt_state == chgctl_pkg::ST_PRECHG);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_cur_ff <= 1'b0;
    end else begin
      fault_cur_ff <= (nxt_state == chgctl_pkg::ST_FAULT) && nxt_fault_low && sense_q.below_rch;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_power_ff <= 1'b1;
    end else begin
      low_power_ff <= idle_power(nxt_state);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vreg_ff <= VREG_LO_MV;
    end else begin
      vreg_ff <= vsel_q ? VREG_HI_MV : VREG_LO_MV;
    end
  end

  // the pads drive a fixed low; only the enables leave the block
  assign status_out_a_oe_o = stat_ff.on_a;
  assign status_out_b_oe_o = stat_ff.on_b;
  assign power_good_n_oe_o = pg_oe_ff;
  assign charge_on_o       = charge_on_ff;
  assign precharge_o       = precharge_ff;
  assign fault_current_o   = fault_cur_ff;
  assign low_power_o       = low_power_ff;
  assign vreg_target_mv_o  = vreg_ff;
  assign state_o           = state_ff;

endmodule // chgctl

// two-flop sync, then the level must hold for CYCLES clocks before it passes
module chgctl_deglitch #(
  parameter int unsigned CYCLES = `CHGCTL_DEGLITCH_CYC,
  parameter logic        INIT   = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic raw_i,
  output logic      clean_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic          sync1_ff;
  logic          sync2_ff;
  logic [CW-1:0] cnt_ff;
  logic          clean_ff;
  logic          settled;

  assign settled = (cnt_ff == CW'(CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= INIT;
      sync2_ff <= INIT;
    end else begin
      sync1_ff <= raw_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else if ((sync2_ff == clean_ff) || settled) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clean_ff <= INIT;
    end else if ((sync2_ff != clean_ff) && settled) begin
      clean_ff <= sync2_ff;
    end
  end

  assign clean_o = clean_ff;
endmodule // chgctl_deglitch

// *** hdl/chgctl_params.svh ***
`ifndef CHGCTL_PARAMS_SVH
`define CHGCTL_PARAMS_SVH
`define CHGCTL_CLK_HZ          50000000
`define CHGCTL_DEGLITCH_US     100
`define CHGCTL_DEGLITCH_CYC    ((`CHGCTL_DEGLITCH_US * (`CHGCTL_CLK_HZ / 1000000)))
`define CHGCTL_PRECHG_S        1800
`define CHGCTL_PRECHG_CYC      (64'(`CHGCTL_PRECHG_S) * 64'(`CHGCTL_CLK_HZ))
`define CHGCTL_FAST_S          25200
`define CHGCTL_FAST_CYC        (64'(`CHGCTL_FAST_S) * 64'(`CHGCTL_CLK_HZ))
`define CHGCTL_VSEL_LO_MV      4200
`define CHGCTL_VSEL_HI_MV      4060
`define CHGCTL_NUM_IN          5
`endif

// *** hdl/chgctl_pkg.sv ***
package chgctl_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP   = 3'b000,
    ST_PRECHG  = 3'b001,
    ST_FAST    = 3'b011,
    ST_DONE    = 3'b010,
    ST_FAULT   = 3'b110,
    ST_DISABLE = 3'b111,
    ST_SUSPEND = 3'b101
  } chgctl_state_type;

  typedef struct packed {
    logic in_present;
    logic above_lowv;
    logic below_rch;
    logic taper_term;
    logic in_regulation;
  } chgctl_sense_type;

  typedef struct packed {
    logic on_a;
    logic on_b;
  } chgctl_stat_type;
endpackage

// *** test/chgctl_deglitch_bench.sv ***
`timescale 1ns/100ps
// host monitor pins with pull-ups: a released pin reads high
module chgctl_host (
  input  wire logic stat_a_oe_i,
  input  wire logic stat_b_oe_i,
  input  wire logic pg_oe_i,
  output logic      stat_a_pin_o,
  output logic      stat_b_pin_o,
  output logic      pg_pin_o
);
  assign stat_a_pin_o = stat_a_oe_i ? 1'b0 : 1'b1;
  assign stat_b_pin_o = stat_b_oe_i ? 1'b0 : 1'b1;
  assign pg_pin_o     = pg_oe_i ? 1'b0 : 1'b1;
endmodule // chgctl_host

module chgctl_bench;
  logic                         clk_sys_i = 1'b0;
  logic                         arst_n_i;
  chgctl_pkg::chgctl_sense_type sense;
  logic                         enable_n;
  logic                         vsel;
  logic                         temp;
  logic                         stat_a_oe;
  logic                         stat_b_oe;
  logic                         pg_oe;
  logic                         charge_on;
  logic                         precharge;
  logic                         fault_cur;
  logic                         low_power;
  logic [12:0]                  vreg_mv;
  chgctl_pkg::chgctl_state_type state_o;
  logic                         stat_a_pin;
  logic                         stat_b_pin;
  logic                         pg_pin;
  int                           mismatches;
  int                           comparisons;

  always #10 clk_sys_i = ~clk_sys_i;

  chgctl #(
    .NUM_SENSE    (32'h5),
    .DEGLITCH_CYC (32'h4),
    .TIMER_W      (32'h29),
    .PRECHG_CYC   (41'h0c8),
    .FAST_CYC     (41'h190)
  ) dut (
    .clk_sys_i                   (clk_sys_i),
    .arst_n_i                    (arst_n_i),
    .sense_i                     (sense),
    .charge_enable_n_i           (enable_n),
    .regulation_voltage_select_i (vsel),
    .temp_suspend_i              (temp),
    .status_out_a_oe_o           (stat_a_oe),
    .status_out_b_oe_o           (stat_b_oe),
    .power_good_n_oe_o           (pg_oe),
    .charge_on_o                 (charge_on),
    .precharge_o                 (precharge),
    .fault_current_o             (fault_cur),
    .low_power_o                 (low_power),
    .vreg_target_mv_o            (vreg_mv),
    .state_o                     (state_o)
  );

  chgctl_host u_host (
    .stat_a_oe_i  (stat_a_oe),
    .stat_b_oe_i  (stat_b_oe),
    .pg_oe_i      (pg_oe),
    .stat_a_pin_o (stat_a_pin),
    .stat_b_pin_o (stat_b_pin),
    .pg_pin_o     (pg_pin)
  );

  task automatic end_sim();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if ((mismatches == 0) && (comparisons > 0)) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
    comparisons++;
    if (seen !== expected) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, expected);
    end
  endtask

  // write task: all pins change together just after a falling edge
  task automatic set_pins(input logic in_p, input logic lowv, input logic rch, input logic taper,
                          input logic reg_ok, input logic en_n, input logic vs, input logic tmp);
    @(negedge clk_sys_i);
    sense.in_present    = in_p;
    sense.above_lowv    = lowv;
    sense.below_rch     = rch;
    sense.taper_term    = taper;
    sense.in_regulation = reg_ok;
    enable_n            = en_n;
    vsel                = vs;
    temp                = tmp;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic check_state(input chgctl_pkg::chgctl_state_type exp, input string what);
    check(16'(state_o), 16'(exp), what);
  endtask

  task automatic check_pins(input logic a, input logic b, input logic pg, input string what);
    check({13'h0000, stat_a_pin, stat_b_pin, pg_pin}, {13'h0000, a, b, pg}, what);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    mismatches  = 0;
    comparisons = 0;
    arst_n_i    = 1'b0;
    sense       = '0;
    enable_n    = 1'b1;
    vsel        = 1'b0;
    temp        = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    settle(4);
    check_state(chgctl_pkg::ST_SLEEP, "sleep after reset");
    check_pins(1'b1, 1'b1, 1'b1, "all released in sleep");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(1);
    set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_SLEEP, "short supply glitch ignored");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_DISABLE, "disabled with supply");
    check(16'(low_power), 16'h0001, "low power when disabled");
    check_pins(1'b1, 1'b1, 1'b0, "power good pulled low");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_PRECHG, "enable starts precharge");
    check_pins(1'b0, 1'b0, 1'b0, "precharge on,on");
    check(16'(precharge), 16'h0001, "precharge current on");
    set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_FAST, "precharge exit to fast");
    check_pins(1'b0, 1'b1, 1'b0, "fast on,off");
    set_pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_DONE, "taper terminates");
    check_pins(1'b1, 1'b0, 1'b0, "done off,on");
    check(16'(charge_on), 16'h0000, "charge off when done");
    set_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_FAST, "recharge restarts");
    settle(420);
    check_state(chgctl_pkg::ST_FAULT, "fast timer fault");
    check(16'(fault_cur), 16'h0001, "fault current while below");
    check_pins(1'b1, 1'b1, 1'b0, "fault off,off");
    set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_FAULT, "fault held above threshold");
    check(16'(fault_cur), 16'h0000, "fault current off above");
    set_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_FAST, "fall below restarts");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_DISABLE, "enable high stops charge");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_PRECHG, "precharge again");
    settle(220);
    check_state(chgctl_pkg::ST_FAULT, "precharge timer fault");
    check(16'(fault_cur), 16'h0000, "no fault current above");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(20);
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_PRECHG, "enable toggle clears fault");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    settle(20);
    check_state(chgctl_pkg::ST_SUSPEND, "temperature suspend");
    check_pins(1'b1, 1'b1, 1'b0, "suspend off,off");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_PRECHG, "resume after suspend");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    settle(20);
    check(16'(vreg_mv), 16'h0fdc, "high select target");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check(16'(vreg_mv), 16'h1068, "low select target");
    set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle(20);
    check_state(chgctl_pkg::ST_SLEEP, "supply loss sleeps");
    check_pins(1'b1, 1'b1, 1'b1, "pins released in sleep");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(20);
    arst_n_i = 1'b0;
    settle(6);
    arst_n_i = 1'b1;
    settle(1);
    check_state(chgctl_pkg::ST_SLEEP, "mid-run reset");
    settle(20);
    check_state(chgctl_pkg::ST_DISABLE, "after mid-run reset");
    end_sim();
  end
endmodule // chgctl_bench

// *** test/chgctl_mon_monitor.sv ***
`timescale 1ns/100ps
module chgctl_mon (
  input wire logic                         clk_sys_i,
  input wire logic                         arst_n_i,
  input wire chgctl_pkg::chgctl_sense_type sense_i,
  input wire logic                         charge_enable_n_i,
  input wire logic                         regulation_voltage_select_i,
  input wire logic                         temp_suspend_i,
  input wire logic                         status_out_a_oe_o,
  input wire logic                         status_out_b_oe_o,
  input wire logic                         power_good_n_oe_o,
  input wire logic                         charge_on_o,
  input wire logic                         precharge_o,
  input wire logic                         fault_current_o,
  input wire logic                         low_power_o,
  input wire logic [12:0]                  vreg_target_mv_o,
  input wire chgctl_pkg::chgctl_state_type state_o
);
  a_pre_both_on: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    precharge_o |-> (status_out_a_oe_o && status_out_b_oe_o))
    else $error("precharge status pattern wrong");
  a_fast_a_only: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (state_o == chgctl_pkg::ST_FAST) |-> (status_out_a_oe_o && !status_out_b_oe_o))
    else $error("fast charge status pattern wrong");
  a_done_b_only: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (state_o == chgctl_pkg::ST_DONE) |-> (!status_out_a_oe_o && status_out_b_oe_o))
    else $error("done status pattern wrong");
  a_sleep_all_off: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (state_o == chgctl_pkg::ST_SLEEP) |-> (!power_good_n_oe_o && !status_out_a_oe_o && !status_out_b_oe_o))
    else $error("sleep leaves a pin driven");
  a_pg_when_awake: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (state_o != chgctl_pkg::ST_SLEEP) |-> power_good_n_oe_o)
    else $error("power good released while awake");
  a_disable_idle: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (state_o == chgctl_pkg::ST_DISABLE) |-> (low_power_o && !charge_on_o))
    else $error("disabled charger still active");
  a_fault_cur_only: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fault_current_o |-> ((state_o == chgctl_pkg::ST_FAULT) && !charge_on_o))
    else $error("fault current outside fault");
  a_vreg_legal: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (vreg_target_mv_o == 13'h1068) || (vreg_target_mv_o == 13'h0fdc))
    else $error("regulation target not a legal choice");
  a_pre_is_charge: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    precharge_o |-> charge_on_o)
    else $error("precharge without charge path");
endmodule // chgctl_mon

bind chgctl chgctl_mon u_mon (
  .clk_sys_i                   (clk_sys_i),
  .arst_n_i                    (arst_n_i),
  .sense_i                     (sense_i),
  .charge_enable_n_i           (charge_enable_n_i),
  .regulation_voltage_select_i (regulation_voltage_select_i),
  .temp_suspend_i              (temp_suspend_i),
  .status_out_a_oe_o           (status_out_a_oe_o),
  .status_out_b_oe_o           (status_out_b_oe_o),
  .power_good_n_oe_o           (power_good_n_oe_o),
  .charge_on_o                 (charge_on_o),
  .precharge_o                 (precharge_o),
  .fault_current_o             (fault_current_o),
  .low_power_o                 (low_power_o),
  .vreg_target_mv_o            (vreg_target_mv_o),
  .state_o                     (state_o)
);
